//--- verilog/quad_serial_cfg.svh
// Constants for the quad-lane serial output stage.
`ifndef QUAD_SERIAL_CFG_SVH
`define QUAD_SERIAL_CFG_SVH

// =====================================================================
// Word and lane geometry
`define WORD_BITS            12
`define LANES                4
`define FIFO_DEPTH           16

// =====================================================================
// Serialiser timing, in link clock cycles (one bit per cycle)
`define LAST_BIT_INDEX       4'hb
`define BIT_CNT_RESET        4'hb
`define FRAME_HIGH_BITS      4'h6

// =====================================================================
// Fixed test words (offset binary)
`define MIDSCALE_WORD        12'h800
`define ALTERNATE_WORD       12'haaa
`define ZERO_WORD            12'h000

// =====================================================================
// Digitised levels of the test-pattern select pin
`define TP_CODE_GROUND       2'h0
`define TP_CODE_MIDSCALE     2'h1
`define TP_CODE_ALTERNATE    2'h2
`define TP_CODE_RESTRICTED   2'h3

`endif

//--- verilog/quad_serial_pkg.sv
// Types shared by the quad-lane serial output stage.
`include "quad_serial_cfg.svh"

package quad_serial_pkg;

    typedef logic [`WORD_BITS-1:0]             sample_word_t;
    typedef logic [`LANES-1:0][`WORD_BITS-1:0] sample_set_t;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_MIDSCALE,
        MODE_ALTERNATE,
        MODE_RESTRICTED
    } test_mode_t;

    typedef enum logic {
        XFER_IDLE,
        XFER_WAIT
    } xfer_state_t;

endpackage : quad_serial_pkg

//--- verilog/word_stream_if.sv
// Valid/ready word stream between the intake FIFO and its neighbours.
`timescale 1ns/100ps

interface word_stream_if #(
    parameter int WIDTH = 48
) ();
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface : word_stream_if

//--- verilog/sample_fifo.sv
// Synchronous FIFO holding sample sets on their way to the serialisers.
`timescale 1ns/100ps

module sample_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 16
) (
    input  wire logic           clk,
    input  wire logic           rst_b,
    input  wire logic           clkEn,
    word_stream_if.sink         fillPort,
    word_stream_if.source       drainPort
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wrPtr_reg;
    logic [AW-1:0]    rdPtr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             inReady_reg;

    wire doWrite = clkEn && fillPort.valid && inReady_reg;
    wire doRead  = clkEn && drainPort.ready && (count_reg != '0);

    assign count_next      = count_reg + (AW+1)'(doWrite) - (AW+1)'(doRead);
    assign fillPort.ready  = inReady_reg;
    assign drainPort.valid = (count_reg != '0);
    assign drainPort.data  = store[rdPtr_reg];

    // Ready is registered so the block's sampleReady output comes from a flop.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_reg   <= '0;
            rdPtr_reg   <= '0;
            count_reg   <= '0;
            inReady_reg <= 1'b1;
        end else if (clkEn) begin
            wrPtr_reg   <= wrPtr_reg + AW'(doWrite);
            rdPtr_reg   <= rdPtr_reg + AW'(doRead);
            count_reg   <= count_next;
            inReady_reg <= (count_next != (AW+1)'(DEPTH));
        end
    end

    always_ff @(posedge clk) begin
        if (doWrite) begin
            store[wrPtr_reg] <= fillPort.data;
        end
    end

endmodule : sample_fifo

//--- verilog/quad_serial_lvds_out.sv
// Quad-lane serial output stage: sample intake, word crossing and DDR lane serialisers.
`timescale 1ns/100ps
`include "quad_serial_cfg.svh"

module quad_serial_lvds_out
    import quad_serial_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic         clkEn,
    input  wire logic         linkClk,
    input  wire logic         sampleValid,
    input  wire sample_set_t  sampleWords,
    output logic              sampleReady,
    input  wire logic [1:0]   testPatternSelect,
    input  wire logic         powerDownInput,
    output logic [`LANES-1:0] laneData,
    output logic              bitClockOut,
    output logic              frameClockOut,
    output logic              driverEnable
);

    // =====================================================================
    // Decoding helpers
    function automatic sample_word_t laneWord(input test_mode_t mode, input sample_word_t sample);
        case (mode)
            MODE_MIDSCALE:  laneWord = `MIDSCALE_WORD;
            MODE_ALTERNATE: laneWord = `ALTERNATE_WORD;
            default:        laneWord = sample;
        endcase
    endfunction : laneWord

    // =====================================================================
    // Sample intake (mclk domain)
    word_stream_if #(.WIDTH(`LANES*`WORD_BITS)) fillSide ();
    word_stream_if #(.WIDTH(`LANES*`WORD_BITS)) drainSide ();

    assign fillSide.valid = sampleValid;
    assign fillSide.data  = sampleWords;
    assign sampleReady    = fillSide.ready;

    sample_fifo #(
        .WIDTH (`LANES*`WORD_BITS),
        .DEPTH (`FIFO_DEPTH)
    ) intake (
        .clk       (mclk),
        .rst_b     (rst_b),
        .clkEn     (clkEn),
        .fillPort  (fillSide.sink),
        .drainPort (drainSide.source)
    );

    // =====================================================================
    // Word crossing, mclk side: a toggle request holds the word steady until acknowledged.
    xfer_state_t xferState_reg;
    xfer_state_t xferState_next;
    sample_set_t xferWord_reg;
    logic        xferReq_reg;
    logic        ackMeta_reg;
    logic        ackSync_reg;
    logic        linkAck_reg;

    wire takeWord = (xferState_reg == XFER_IDLE) && drainSide.valid;
    wire ackSeen  = (ackSync_reg == xferReq_reg);

    assign drainSide.ready = (xferState_reg == XFER_IDLE);

    always_comb begin
        case (xferState_reg)
            XFER_IDLE: xferState_next = drainSide.valid ? XFER_WAIT : XFER_IDLE;
            XFER_WAIT: xferState_next = ackSeen ? XFER_IDLE : XFER_WAIT;
            default:   xferState_next = XFER_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            xferState_reg <= XFER_IDLE;
            xferWord_reg  <= '0;
            xferReq_reg   <= 1'b0;
        end else if (clkEn) begin
            xferState_reg <= xferState_next;
            if (takeWord) begin
                xferWord_reg <= drainSide.data;
                xferReq_reg  <= ~xferReq_reg;
            end
        end
    end

    // Synchronisers run regardless of the clock enable so a frozen side wakes cleanly.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ackMeta_reg <= 1'b0;
            ackSync_reg <= 1'b0;
        end else begin
            ackMeta_reg <= linkAck_reg;
            ackSync_reg <= ackMeta_reg;
        end
    end

    // =====================================================================
    // Link domain reset release and pin synchronisers
    logic       rstLinkMeta_b;
    logic       rstLink_b;
    logic       reqMeta_reg;
    logic       reqSync_reg;
    logic       enMeta_reg;
    logic       enLink_reg;
    logic [1:0] tpMeta_reg;
    logic [1:0] tpSync_reg;
    logic       pdMeta_reg;
    logic       pdSync_reg;

    always_ff @(posedge linkClk or negedge rst_b) begin
        if (!rst_b) begin
            rstLinkMeta_b <= 1'b0;
            rstLink_b     <= 1'b0;
        end else begin
            rstLinkMeta_b <= 1'b1;
            rstLink_b     <= rstLinkMeta_b;
        end
    end

    always_ff @(posedge linkClk or negedge rstLink_b) begin
        if (!rstLink_b) begin
            reqMeta_reg <= 1'b0;
            reqSync_reg <= 1'b0;
            enMeta_reg  <= 1'b0;
            enLink_reg  <= 1'b0;
            tpMeta_reg  <= `TP_CODE_GROUND;
            tpSync_reg  <= `TP_CODE_GROUND;
            pdMeta_reg  <= 1'b0;
            pdSync_reg  <= 1'b0;
        end else begin
            reqMeta_reg <= xferReq_reg;
            reqSync_reg <= reqMeta_reg;
            enMeta_reg  <= clkEn;
            enLink_reg  <= enMeta_reg;
            tpMeta_reg  <= testPatternSelect;
            tpSync_reg  <= tpMeta_reg;
            pdMeta_reg  <= powerDownInput;
            pdSync_reg  <= pdMeta_reg;
        end
    end

    // =====================================================================
    // Serialiser control (link domain), one bit per link clock cycle
    logic [3:0]  bitCnt_reg;
    logic [3:0]  bitCnt_next;
    sample_set_t lastWord_reg;
    test_mode_t  modeWord_reg;
    logic        bitClock_reg;
    logic        frameClock_reg;
    logic        driverEnable_reg;
    logic [`LANES-1:0] loadMsb;

    wire         wordEnd  = (bitCnt_reg == `LAST_BIT_INDEX);
    wire         newWord  = (reqSync_reg != linkAck_reg);
    // The crossed word is only read while the request is pending, so it is stable here.
    wire sample_set_t nextWord = newWord ? xferWord_reg : lastWord_reg;
    wire test_mode_t  pinMode  = (tpSync_reg == `TP_CODE_MIDSCALE)   ? MODE_MIDSCALE :
                                 (tpSync_reg == `TP_CODE_ALTERNATE)  ? MODE_ALTERNATE :
                                 (tpSync_reg == `TP_CODE_RESTRICTED) ? MODE_RESTRICTED : MODE_NORMAL;

    assign bitCnt_next = wordEnd ? 4'h0 : bitCnt_reg + 4'h1;

    // A new word is taken only at a word boundary, one per frame, so the FIFO backs up
    // honestly instead of dropping words when the link is slower than the intake.
    always_ff @(posedge linkClk or negedge rstLink_b) begin
        if (!rstLink_b) begin
            bitCnt_reg       <= `BIT_CNT_RESET;
            lastWord_reg     <= '0;
            modeWord_reg     <= MODE_NORMAL;
            linkAck_reg      <= 1'b0;
            bitClock_reg     <= 1'b0;
            frameClock_reg   <= 1'b0;
            driverEnable_reg <= 1'b0;
        end else if (enLink_reg) begin
            bitCnt_reg       <= bitCnt_next;
            bitClock_reg     <= ~bitClock_reg;
            frameClock_reg   <= (bitCnt_next < `FRAME_HIGH_BITS);
            driverEnable_reg <= ~pdSync_reg;
            if (wordEnd) begin
                modeWord_reg <= pinMode;
                lastWord_reg <= nextWord;
                if (newWord) begin
                    linkAck_reg <= reqSync_reg;
                end
            end
        end
    end

    assign bitClockOut   = bitClock_reg;
    assign frameClockOut = frameClock_reg;
    assign driverEnable  = driverEnable_reg;

    // =====================================================================
    // Lane shifters
    for (genvar lane = 0; lane < `LANES; lane++) begin : g_lane
        sample_word_t shift_reg;
        wire sample_word_t loadWord = laneWord(pinMode, nextWord[lane]);

        assign loadMsb[lane]  = loadWord[`WORD_BITS-1];
        assign laneData[lane] = shift_reg[`WORD_BITS-1];

        always_ff @(posedge linkClk or negedge rstLink_b) begin
            if (!rstLink_b) begin
                shift_reg <= `ZERO_WORD;
            end else if (enLink_reg) begin
                if (wordEnd) begin
                    shift_reg <= loadWord;
                end else begin
                    shift_reg <= {shift_reg[`WORD_BITS-2:0], 1'b0};
                end
            end
        end
    end

    // =====================================================================
    // Assertions
    property p_xfer_stable;
        @(posedge mclk) disable iff (!rst_b)
        (xferState_reg == XFER_WAIT) |=> $stable(xferWord_reg);
    endproperty
    a_xfer_stable: assert property (p_xfer_stable) else $error("Crossing word changed while pending.");

    property p_frame_period;
        @(posedge linkClk) disable iff (!rstLink_b || !enLink_reg)
        $rose(frameClockOut) |-> ##12 $rose(frameClockOut);
    endproperty
    a_frame_period: assert property (p_frame_period) else $error("Frame period is not twelve bits.");

    property p_frame_high;
        @(posedge linkClk) disable iff (!rstLink_b || !enLink_reg)
        $rose(frameClockOut) |-> frameClockOut[*6] ##1 !frameClockOut;
    endproperty
    a_frame_high: assert property (p_frame_high) else $error("Frame clock high phase is not six bits.");

    property p_bit_clock_toggle;
        @(posedge linkClk) disable iff (!rstLink_b)
        enLink_reg |=> (bitClockOut != $past(bitClockOut));
    endproperty
    a_bit_clock_toggle: assert property (p_bit_clock_toggle) else $error("Bit clock missed a toggle.");

    property p_bit_clock_at_frame;
        @(posedge linkClk) disable iff (!rstLink_b || !enLink_reg)
        $rose(frameClockOut) |-> bitClockOut ##2 bitClockOut ##10 $rose(frameClockOut) && bitClockOut;
    endproperty
    a_bit_clock_at_frame: assert property (p_bit_clock_at_frame) else $error("Bit clock out of step with frame.");

    property p_msb_first;
        @(posedge linkClk) disable iff (!rstLink_b || !enLink_reg)
        $rose(frameClockOut) |-> (laneData == $past(loadMsb));
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("First lane bit is not the word MSB.");

    property p_midscale_word;
        @(posedge linkClk) disable iff (!rstLink_b || !enLink_reg)
        ($rose(frameClockOut) && modeWord_reg == MODE_MIDSCALE) |->
            (laneData == {`LANES{1'b1}}) ##1 (laneData == {`LANES{1'b0}})[*8];
    endproperty
    a_midscale_word: assert property (p_midscale_word) else $error("Midscale test word wrong.");

    property p_alternate_word;
        @(posedge linkClk) disable iff (!rstLink_b || !enLink_reg)
        ($rose(frameClockOut) && modeWord_reg == MODE_ALTERNATE) |->
            (laneData == {`LANES{1'b1}}) ##1 (laneData == {`LANES{1'b0}}) ##1
            (laneData == {`LANES{1'b1}}) ##1 (laneData == {`LANES{1'b0}});
    endproperty
    a_alternate_word: assert property (p_alternate_word) else $error("Alternating test word wrong.");

    property p_power_down;
        @(posedge linkClk) disable iff (!rstLink_b)
        (enLink_reg && pdSync_reg) |=> !driverEnable;
    endproperty
    a_power_down: assert property (p_power_down) else $error("Drivers enabled in power-down.");

    property p_power_up;
        @(posedge linkClk) disable iff (!rstLink_b)
        (enLink_reg && !pdSync_reg) |=> driverEnable;
    endproperty
    a_power_up: assert property (p_power_up) else $error("Drivers not restored after power-down.");

    property p_cov_handoff;
        @(posedge linkClk) disable iff (!rstLink_b)
        enLink_reg && wordEnd && newWord;
    endproperty
    c_cov_handoff: cover property (p_cov_handoff);

    property p_cov_midscale;
        @(posedge linkClk) disable iff (!rstLink_b)
        $rose(frameClockOut) && modeWord_reg == MODE_MIDSCALE;
    endproperty
    c_cov_midscale: cover property (p_cov_midscale);

    property p_cov_alternate;
        @(posedge linkClk) disable iff (!rstLink_b)
        $rose(frameClockOut) && modeWord_reg == MODE_ALTERNATE;
    endproperty
    c_cov_alternate: cover property (p_cov_alternate);

    property p_cov_full;
        @(posedge mclk) disable iff (!rst_b)
        sampleValid && !sampleReady;
    endproperty
    c_cov_full: cover property (p_cov_full);

endmodule : quad_serial_lvds_out

//--- verification/lvds_word_receiver.sv
// Behavioural deserialising receiver at the far end of the four lanes.
`timescale 1ns/100ps

module lvds_word_receiver
    import quad_serial_pkg::*;
(
    input  wire logic        linkClk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  laneData,
    input  wire logic        bitClockOut,
    input  wire logic        frameClockOut,
    input  wire logic        driverEnable,
    output sample_set_t      rxSet,
    output logic             rxStrobe,
    output logic [15:0]      clkFaults
);
    sample_set_t shiftSet;
    logic [3:0]  pos;
    logic        locked;
    logic        framePrev;

    // =====================================================================
    // Capture
    // The falling link edge sits mid-bit, away from the rising link edge where lanes and bit clock change.
    always @(negedge linkClk or negedge rst_b) begin
        sample_set_t s;
        logic [3:0]  np;
        if (!rst_b) begin
            shiftSet  <= '0;
            rxSet     <= '0;
            rxStrobe  <= 1'b0;
            clkFaults <= 16'h0;
            pos       <= 4'h0;
            locked    <= 1'b0;
            framePrev <= 1'b0;
        end else begin
            rxStrobe  <= 1'b0;
            framePrev <= frameClockOut;
            np = (frameClockOut === 1'b1 && framePrev === 1'b0) ? 4'h0 : pos + 4'h1;
            for (int n = 0; n < 4; n++) begin
                s[n] = {shiftSet[n][10:0], laneData[n]};
            end
            // Released drivers carry nothing usable, so alignment is dropped until the next frame.
            if (driverEnable !== 1'b1) begin
                locked <= 1'b0;
            end else if (locked || np == 4'h0) begin
                if ((np == 4'h0 && locked && pos != 4'hb) || np > 4'hb
                    || frameClockOut !== (np < 4'h6) || bitClockOut !== ~np[0]) begin
                    clkFaults <= clkFaults + 16'h1;
                end
                locked   <= 1'b1;
                pos      <= np;
                shiftSet <= s;
                if (np == 4'hb) begin
                    rxSet    <= s;
                    rxStrobe <= 1'b1;
                end
            end
        end
    end
endmodule : lvds_word_receiver

//--- verification/tb.sv
// Self-checking bench for the quad-lane serial output stage.
`timescale 1ns/100ps

module tb
    import quad_serial_pkg::*;
;
    logic        mclk;
    logic        linkClk;
    logic        rst_b;
    logic        clkEn;
    logic        sampleValid;
    sample_set_t sampleWords;
    logic        sampleReady;
    logic [1:0]  testPatternSelect;
    logic        powerDownInput;
    logic [3:0]  laneData;
    logic        bitClockOut;
    logic        frameClockOut;
    logic        driverEnable;
    sample_set_t rxSet;
    logic        rxStrobe;
    logic [15:0] clkFaults;
    int          err_total;
    int          num_checks;
    int          cycles;
    int          bitEdges;
    int          edgeMark;
    int          skipWords;
    int          wordsSeen;
    logic [31:0] lfsrState;
    sample_set_t expQ[$];
    sample_set_t lastSet;
    logic [11:0] patWord;
    logic        usePat;
    logic        sawFull;

    quad_serial_lvds_out u_quad_serial_lvds_out (
        .mclk(mclk), .rst_b(rst_b), .clkEn(clkEn), .linkClk(linkClk),
        .sampleValid(sampleValid), .sampleWords(sampleWords), .sampleReady(sampleReady),
        .testPatternSelect(testPatternSelect), .powerDownInput(powerDownInput),
        .laneData(laneData), .bitClockOut(bitClockOut), .frameClockOut(frameClockOut),
        .driverEnable(driverEnable));

    lvds_word_receiver u_lvds_word_receiver (
        .linkClk(linkClk), .rst_b(rst_b), .laneData(laneData), .bitClockOut(bitClockOut),
        .frameClockOut(frameClockOut), .driverEnable(driverEnable),
        .rxSet(rxSet), .rxStrobe(rxStrobe), .clkFaults(clkFaults));

    // =====================================================================
    // Clocks and watchdog
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // Word rate is link/12, about 13.9 MHz, above the lowest conversion rate.
    initial begin
        linkClk = 1'b0;
        #1.7;
        forever #3 linkClk = ~linkClk;
    end

    // Counts bit clock periods, since a bit clock sampled now and then can look still while running.
    always @(posedge bitClockOut) bitEdges++;

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            final_report();
        end
    end

    // =====================================================================
    // Helpers
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic sample_set_t next_set();
        sample_set_t s;
        for (int k = 0; k < 48; k++) begin
            lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
            s = {s[46:0], lfsrState[0]};
        end
        return s;
    endfunction : next_set

    // Entered at a rising mclk edge; ready is read mid-cycle to stay clear of the edge.
    task automatic send_set(input sample_set_t s);
        int k;
        k = 0;
        sampleWords <= s;
        sampleValid <= 1'b1;
        @(negedge mclk);
        while (sampleReady !== 1'b1 && k < 1000) begin
            sawFull = 1'b1;
            k++;
            @(negedge mclk);
        end
        @(posedge mclk);
        expQ.push_back(s);
    endtask : send_set

    task automatic pause_words(input int n);
        int target;
        int k;
        target = wordsSeen + n;
        k = 0;
        while (wordsSeen < target && k < 3000) begin
            k++;
            @(posedge mclk);
        end
    endtask : pause_words

    task automatic drain();
        sampleValid <= 1'b0;
        pause_words(2);
        while (expQ.size() != 0 && wordsSeen < 5000) pause_words(1);
        check(48'(expQ.size()), 48'h0);
        check(48'(clkFaults), 48'h0);
    endtask : drain

    task automatic end_test(input string name);
        $display("test %s done: checks=%0d mismatches=%0d", name, num_checks, err_total);
    endtask : end_test

    task automatic final_report();
        $display("total checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    // =====================================================================
    // Receiver-side model: repeats of the last set are legal while the buffer is empty
    always @(posedge linkClk) begin
        if (rxStrobe === 1'b1) begin
            wordsSeen++;
            if (skipWords > 0) begin
                skipWords--;
            end else if (usePat) begin
                check(rxSet, {4{patWord}});
            end else begin
                if (expQ.size() > 0 && rxSet === expQ[0]) lastSet = expQ.pop_front();
                check(rxSet, lastSet);
            end
        end
    end

    // =====================================================================
    // Main sequence
    initial begin
        rst_b = 1'b0;
        clkEn = 1'b1;
        sampleValid = 1'b0;
        sampleWords = '0;
        testPatternSelect = 2'h0;
        powerDownInput = 1'b0;
        lfsrState = 32'h925907b2;
        lastSet = '0;
        usePat = 1'b0;
        patWord = 12'h000;
        sawFull = 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        send_set({12'hfff, 12'h000, 12'h800, 12'h7ff});
        send_set({12'h000, 12'hfff, 12'h001, 12'hffe});
        for (int i = 0; i < 40; i++) send_set(next_set());
        drain();
        check(48'(sawFull), 48'h1);
        end_test("stream");
        for (int sel = 1; sel < 4; sel++) begin
            testPatternSelect <= sel[1:0];
            usePat = (sel != 3);
            patWord = (sel == 1) ? 12'h800 : 12'haaa;
            skipWords = 3;
            pause_words(8);
            if (sel == 3) send_set(next_set());
            drain();
            end_test("pattern");
        end
        testPatternSelect <= 2'h0;
        usePat = 1'b0;
        skipWords = 3;
        pause_words(4);
        powerDownInput <= 1'b1;
        repeat (8) @(posedge mclk);
        check(48'(driverEnable), 48'h0);
        // Clock enable low must freeze the link side as well, bit clock included.
        clkEn <= 1'b0;
        repeat (2) @(posedge mclk);
        edgeMark = bitEdges;
        repeat (4) @(posedge mclk);
        check(48'(bitEdges - edgeMark), 48'h0);
        clkEn <= 1'b1;
        repeat (2) @(posedge mclk);
        check(48'(bitEdges > edgeMark), 48'h1);
        powerDownInput <= 1'b0;
        skipWords = 2;
        repeat (8) @(posedge mclk);
        check(48'(driverEnable), 48'h1);
        send_set(next_set());
        send_set(next_set());
        drain();
        end_test("powerdown");
        final_report();
    end
endmodule : tb
